/* File: cic_top.sv */
/*
  Interrupt flags, enables, priority arbitration and forced-call sequencing
  with a classic Wishbone register slave.
  Assumes peripherals and core run on CLK_I; event inputs are one-cycle
  pulses and need no synchroniser. One clock equals one machine cycle.
*/
// How it works
// - Eighteen sources, each with its own request flag bit.
// - Every source has its own enable bit, spread over three registers.
// - Sources fall in six groups, each with a software priority level.
// - Eight peripherals merge masked internal events into one request.
// - Vector is 03h plus eight times the source number.
// - Source 9 is the wide timer request, vector 4Bh.
// - Source 11 is the first narrow timer request, vector 5Bh.
// - Source 12 is the second narrow timer request, vector 63h.
// - Source 17 is watchdog overflow in timer mode only, vector 8Bh.
// - Flags set on their event whether or not the source is enabled.
// - Enabled flag is answered next instruction cycle by a forced call.
// - Only strictly higher priority preempts; return ends service.
// - Fastest response: one detect cycle then six call cycles.
`timescale 1ns/1ns

module cic_top
  import cic_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  // Wishbone slave
  input  wire logic                  CYC_I,
  input  wire logic                  STB_I,
  input  wire logic                  WE_I,
  input  wire logic [3:0]            SEL_I,
  input  wire logic [7:0]            ADR_I,
  input  wire logic [31:0]           DAT_I,
  output logic      [31:0]           DAT_O,
  output logic                       ACK_O,
  // Peripheral events
  input  wire logic [cic_pkg::NUM_SRC-1:0] SRC_EVENT_I,
  input  wire logic [cic_pkg::NUM_MERGED*cic_pkg::EV_W-1:0] MERGED_EVENT_I,
  input  wire logic                  WDT_TIMER_MODE_I,
  // Instruction sequencer
  input  wire logic                  INSTR_BOUNDARY_I,
  input  wire logic                  RETURN_FROM_IRQ_I,
  output cic_pkg::cic_call_s         CALL_O,
  output logic                       IRQ_O
);
  import cic_pkg::*;

  logic                          rst_meta;
  logic                          rst_n;
  logic                          glb_en;
  logic [NUM_SRC-1:0]            flag;
  logic [NUM_SRC-1:0]            src_en;
  logic [NUM_GROUP*LVL_W-1:0]    prio;
  logic [EV_W-1:0]               evmask [NUM_MERGED];
  logic [NUM_SRC-1:0]            set_ev;
  logic [NUM_SRC-1:0]            pend;
  logic [3:0]                    in_service;
  logic [3:0]                    next_in_service;
  cic_state_e                    state;
  cic_state_e                    next_state;
  logic [2:0]                    call_cnt;
  logic [4:0]                    best_src;
  logic [LVL_W-1:0]              best_lvl;
  logic                          best_ok;
  logic [4:0]                    take_src;
  logic [LVL_W-1:0]              take_lvl;
  logic                          can_take;
  logic [2:0]                    isv_top;
  logic                          bus_req;
  logic                          wr;
  logic [31:0]                   wmask;
  logic [31:0]                   rdata;

  // Byte lanes of a write, expanded to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Priority level of a source; groups are source number modulo six
  function automatic logic [LVL_W-1:0] src_level(
    input logic [4:0] s, input logic [NUM_GROUP*LVL_W-1:0] p);
    int g;
    g = int'(s) % NUM_GROUP;
    src_level = p[g*LVL_W +: LVL_W];
  endfunction

  // Highest in-service level, or none
  function automatic logic [2:0] top_level(input logic [3:0] isv);
    top_level = 3'b000;
    for (int i = 0; i < 4; i++) begin
      if (isv[i]) begin
        top_level = {1'b1, 2'(i)};
      end
    end
  endfunction

  // Read back one of the three enable registers
  function automatic logic [5:0] en_word(input int r,
                                         input logic [NUM_SRC-1:0] en);
    en_word = 6'h00;
    for (int b = 0; b < 6; b++) begin
      en_word[b] = en[EN_MAP[r*6+b]];
    end
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign bus_req = CYC_I & STB_I & ~ACK_O;
  assign wr      = bus_req & WE_I;
  assign wmask   = lane_mask(SEL_I);

  // Event gathering: merged peripherals pass their own masks first
  always_comb begin
    set_ev = SRC_EVENT_I;
    // Watchdog counts as a source only in timer mode
    set_ev[WDT_SRC] = SRC_EVENT_I[WDT_SRC] & WDT_TIMER_MODE_I;
    for (int k = 0; k < NUM_MERGED; k++) begin
      set_ev[MERGED_SRC[k]] =
        |(MERGED_EVENT_I[k*EV_W +: EV_W] & evmask[k]);
    end
  end

  // Flags ignore enables; a new event beats a same-cycle clear
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      flag <= RST_FLAG;
    end else if (wr && ADR_I == OFS_FLAG) begin
      flag <= (flag & ~(DAT_I[NUM_SRC-1:0] & wmask[NUM_SRC-1:0]))
            | set_ev;
    end else begin
      flag <= flag | set_ev;
    end
  end

  // Global enable and the three source enable registers
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      glb_en <= 1'b0;
      src_en <= RST_EN;
    end else if (wr && SEL_I[0]) begin
      if (ADR_I == OFS_CTRL) begin
        glb_en <= DAT_I[GLB_EN_BIT];
      end
      for (int r = 0; r < 3; r++) begin
        if (ADR_I == OFS_EN0 + 8'(4*r)) begin
          for (int b = 0; b < 6; b++) begin
            src_en[EN_MAP[r*6+b]] <= DAT_I[b];
          end
        end
      end
    end
  end

  // Group priority levels
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      prio <= RST_PRIO;
    end else if (wr && ADR_I == OFS_PRIO) begin
      prio <= (prio & ~wmask[11:0]) | (DAT_I[11:0] & wmask[11:0]);
    end
  end

  // Per-event masks of the merged peripherals
  generate
    for (genvar k = 0; k < NUM_MERGED; k++) begin : g_mask
      always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          evmask[k] <= RST_MASK;
        end else if (wr && SEL_I[0] && ADR_I == OFS_EVMASK + 8'(4*k)) begin
          evmask[k] <= DAT_I[EV_W-1:0];
        end
      end
    end
  endgenerate

  // Only flagged, enabled sources under global enable compete
  assign pend = flag & src_en & {NUM_SRC{glb_en}};

  // Arbitration: highest level wins, lower source number breaks ties
  always_comb begin
    best_src = 5'd0;
    best_lvl = '0;
    best_ok  = 1'b0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (pend[s] && (!best_ok || src_level(5'(s), prio) >= best_lvl)) begin
        best_src = 5'(s);
        best_lvl = src_level(5'(s), prio);
        best_ok  = 1'b1;
      end
    end
  end

  // Top in-service level, shared by arbitration and return
  assign isv_top = top_level(in_service);
  // Equal or lower priority waits until service above it ends
  always_comb begin
    can_take = best_ok && (!isv_top[2] ||
               best_lvl > isv_top[1:0]);
  end

  // Sequencing: detect at an instruction boundary, then the forced call
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (INSTR_BOUNDARY_I && can_take) begin
          next_state = ST_DETECT;
        end
      end
      ST_DETECT: begin
        next_state = ST_CALL;
      end
      ST_CALL: begin
        if (call_cnt == 3'd0) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Winner is frozen at detection so a late flag cannot redirect the call
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      take_src <= 5'd0;
      take_lvl <= '0;
    end else if (state == ST_IDLE && next_state == ST_DETECT) begin
      take_src <= best_src;
      take_lvl <= best_lvl;
    end
  end

  // Six cycles of forced call after the detect cycle
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      call_cnt <= 3'd0;
    end else if (state == ST_DETECT) begin
      call_cnt <= CALL_CNT_LAST;
    end else if (state == ST_CALL && call_cnt != 3'd0) begin
      call_cnt <= call_cnt - 3'd1;
    end
  end

  // Levels in service: call entry pushes, return pops the top one
  always_comb begin
    next_in_service = in_service;
    if (RETURN_FROM_IRQ_I && isv_top[2]) begin
      next_in_service[isv_top[1:0]] = 1'b0;
    end
    if (state == ST_DETECT) begin
      next_in_service[take_lvl] = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      in_service <= 4'h0;
    end else begin
      in_service <= next_in_service;
    end
  end

  // Call outputs; vector is base plus eight per source number
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CALL_O <= '0;
    end else begin
      CALL_O.start  <= (state == ST_DETECT);
      CALL_O.active <= (next_state == ST_CALL);
      CALL_O.source <= take_src;
      // 9 -> 4Bh, 11 -> 5Bh, 12 -> 63h, 17 -> 8Bh
      CALL_O.vector <= VEC_BASE + VEC_STEP * 16'(take_src);
    end
  end

  // Level interrupt: any enabled flag under global enable
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |pend;
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (ADR_I)
      OFS_CTRL:  rdata[GLB_EN_BIT] = glb_en;
      OFS_EN0:   rdata[5:0] = en_word(0, src_en);
      OFS_EN1:   rdata[5:0] = en_word(1, src_en);
      OFS_EN2:   rdata[5:0] = en_word(2, src_en);
      OFS_FLAG:  rdata[NUM_SRC-1:0] = flag;
      OFS_PRIO:  rdata[11:0] = prio;
      OFS_STATE: begin
        rdata[ST_ISV_POS +: 4] = in_service;
        rdata[ST_SRC_POS +: 5] = take_src;
        rdata[ST_BUSY_BIT]     = (state != ST_IDLE);
      end
      default: begin
        for (int k = 0; k < NUM_MERGED; k++) begin
          if (ADR_I == OFS_EVMASK + 8'(4*k)) begin
            rdata[EV_W-1:0] = evmask[k];
          end
        end
      end
    endcase
  end

  // Bus answer: one wait state, ack for one cycle
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= bus_req;
      if (bus_req && !WE_I) begin
        DAT_O <= rdata;
      end
    end
  end

endmodule // cic_top

/* File: cic_pkg.sv */
/*
  Constants, register map and carrier types for the interrupt controller.
  Assumes a 32-bit classic Wishbone bus and one machine cycle per clock.
*/
package cic_pkg;

  localparam int NUM_SRC    = 18;
  localparam int NUM_MERGED = 8;
  localparam int EV_W       = 8;
  localparam int NUM_GROUP  = 6;
  localparam int LVL_W      = 2;

  // Byte offsets on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_EN0    = 8'h04;
  localparam logic [7:0] OFS_EN1    = 8'h08;
  localparam logic [7:0] OFS_EN2    = 8'h0C;
  localparam logic [7:0] OFS_FLAG   = 8'h10;
  localparam logic [7:0] OFS_PRIO   = 8'h14;
  localparam logic [7:0] OFS_STATE  = 8'h18;
  localparam logic [7:0] OFS_EVMASK = 8'h20;

  // Field positions
  localparam int GLB_EN_BIT  = 0;
  localparam int ST_ISV_POS  = 0;
  localparam int ST_SRC_POS  = 8;
  localparam int ST_BUSY_BIT = 16;

  // Values after reset
  localparam logic [NUM_SRC-1:0]           RST_FLAG = 18'h0_0000;
  localparam logic [NUM_SRC-1:0]           RST_EN   = 18'h0_0000;
  localparam logic [NUM_GROUP*LVL_W-1:0]   RST_PRIO = 12'h000;
  localparam logic [EV_W-1:0]              RST_MASK = 8'h00;

  // Vector table: base and step per source number
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // Response timing in machine cycles
  localparam int DETECT_CYCLES = 1;
  localparam int LONG_SUBROUTINE_CALL_CYCLES  = 6;
  localparam logic [2:0] CALL_CNT_LAST = 3'(LONG_SUBROUTINE_CALL_CYCLES - 1);

  // Source numbers that merge several peripheral events
  localparam logic [4:0] MERGED_SRC [NUM_MERGED] =
    '{5'd13, 5'd15, 5'd6, 5'd8, 5'd9, 5'd11, 5'd12, 5'd16};
  localparam logic [4:0] WDT_SRC = 5'd17;

  // Enable register r, bit b steers source EN_MAP[r*6+b]
  localparam logic [4:0] EN_MAP [NUM_SRC] =
    '{5'd0, 5'd1, 5'd2, 5'd3, 5'd4, 5'd5,
      5'd8, 5'd9, 5'd10, 5'd11, 5'd12, 5'd13,
      5'd16, 5'd6, 5'd7, 5'd14, 5'd15, 5'd17};

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DETECT = 3'b010,
    ST_CALL   = 3'b100
  } cic_state_e;

  // Forced call presented to the instruction sequencer
  typedef struct packed {
    logic        start;
    logic        active;
    logic [4:0]  source;
    logic [15:0] vector;
  } cic_call_s;

endpackage

/* File: cic_assertions.sv */
/*
  Port checker for the interrupt controller: bus answer, forced-call shape,
  vectors and call conditions.
  Assumes one clock; bound to cic_top and sees only its ports.
*/
`timescale 1ns/1ns

module cic_checker
  import cic_pkg::*;
(
  // Clock, reset and bus
  input wire logic              CLK_I,
  input wire logic              RST_N_I,
  input wire logic              CYC_I,
  input wire logic              STB_I,
  input wire logic              ACK_O,
  // Sequencer side
  input wire logic              INSTR_BOUNDARY_I,
  input wire cic_pkg::cic_call_s CALL_O,
  input wire logic              IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Bus answers exactly one cycle after the request is taken
  property p_ack_answer;
    CYC_I && STB_I && !ACK_O |=> ACK_O;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("bus answer missing");
  property p_ack_pulse;
    ACK_O |=> !ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  // Vector is base plus eight bytes per source
  property p_vector;
    CALL_O.start |-> CALL_O.vector == 16'h0003 + {8'h00, CALL_O.source, 3'h0};
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector does not match source");
  // Timer and watchdog sources have fixed vectors
  property p_fixed_vec;
    CALL_O.start |-> (CALL_O.source != 5'h09 || CALL_O.vector == 16'h004B)
      && (CALL_O.source != 5'h0B || CALL_O.vector == 16'h005B)
      && (CALL_O.source != 5'h0C || CALL_O.vector == 16'h0063)
      && (CALL_O.source != 5'h11 || CALL_O.vector == 16'h008B);
  endproperty
  a_fixed_vec: assert property (p_fixed_vec)
    else $error("timer or watchdog vector wrong");
  // A call needs a presented request and a boundary two samples back
  property p_call_irq;
    CALL_O.start |-> $past(IRQ_O);
  endproperty
  a_call_irq: assert property (p_call_irq)
    else $error("call without request");
  property p_call_boundary;
    CALL_O.start |-> $past(INSTR_BOUNDARY_I, 2);
  endproperty
  a_call_boundary: assert property (p_call_boundary)
    else $error("call not after instruction boundary");
  property p_start_rise;
    CALL_O.start |-> $rose(CALL_O.active);
  endproperty
  a_start_rise: assert property (p_start_rise)
    else $error("start without fresh call");
  property p_start_pulse;
    CALL_O.start |=> !CALL_O.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  // The forced call lasts six machine cycles
  property p_active_six;
    $rose(CALL_O.active) |-> CALL_O.active [*6] ##1 !CALL_O.active;
  endproperty
  a_active_six: assert property (p_active_six)
    else $error("call length not six cycles");

  c_wdt_call: cover property (CALL_O.start && CALL_O.source == 5'h11);
  c_preempt: cover property (CALL_O.start && CALL_O.source == 5'h03);
  c_irq_drop: cover property ($fell(IRQ_O));
endmodule // cic_checker

bind cic_top cic_checker cic_checker_i (
  .CLK_I(CLK_I),
  .RST_N_I(RST_N_I),
  .CYC_I(CYC_I),
  .STB_I(STB_I),
  .ACK_O(ACK_O),
  .INSTR_BOUNDARY_I(INSTR_BOUNDARY_I),
  .CALL_O(CALL_O),
  .IRQ_O(IRQ_O)
);

/* File: cic_seq_model.sv */
/*
  Instruction sequencer model: instruction boundaries and return pulses.
  Assumes the bench clock; slow mode mimics multi-cycle instructions.
*/
`timescale 1ns/1ns

module cic_seq_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Bench control
  input  wire logic slow_i,
  input  wire logic ret_req_i,
  // Toward the controller
  output logic      boundary_o,
  output logic      return_from_irq_o
);
  logic [1:0] phase;

  // Slow mode leaves a boundary only every third cycle, so late takes show
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase      <= 2'h0;
      boundary_o <= 1'b0;
      return_from_irq_o     <= 1'b0;
    end else begin
      phase      <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      boundary_o <= !slow_i || phase == 2'h1;
      return_from_irq_o     <= ret_req_i; // Return ends service, one pulse
    end
  end
endmodule // cic_seq_model

/* File: cpu_interrupt_controller_bench.sv */
/*
  Self-checking bench: register access over Wishbone, events, forced calls.
  Assumes cic_top, cic_seq_model and the bound checker.
*/
`timescale 1ns/1ns

module cpu_interrupt_controller_bench;
  import cic_pkg::*;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [31:0]        dat_w = 32'h0000_0000;
  logic [31:0]        dat_r;
  logic               ack;
  logic [NUM_SRC-1:0] src_ev = '0;
  logic [63:0]        mrg_ev = '0;
  logic               wdt_mode = 1'b0;
  logic               slow = 1'b0;
  logic               ret_req = 1'b0;
  logic               boundary;
  logic               return_from_irq;
  cic_call_s          call;
  logic               irq;
  logic [31:0]        q;
  logic [7:0]         ea;
  int                 bad_count = 0;
  int                 checked = 0;
  int                 k;
  int                 e;
  logic [7:0] ra [8] = '{OFS_CTRL, OFS_EN0, OFS_EN1, OFS_EN2, OFS_FLAG,
                         OFS_PRIO, OFS_STATE, 8'h40};

  // 50 MHz clock
  always #10 clk = ~clk;

  cic_top cic_top_i (
    .CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .SEL_I(4'hF), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .SRC_EVENT_I(src_ev), .MERGED_EVENT_I(mrg_ev),
    .WDT_TIMER_MODE_I(wdt_mode), .INSTR_BOUNDARY_I(boundary),
    .RETURN_FROM_IRQ_I(return_from_irq), .CALL_O(call), .IRQ_O(irq));
  cic_seq_model cic_seq_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .ret_req_i(ret_req),
    .boundary_o(boundary), .return_from_irq_o(return_from_irq));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  // Classic single cycle; read data lands in q at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  function automatic int mk(input int s);
    mk = -1;
    for (int i = 0; i < NUM_MERGED; i++) if (MERGED_SRC[i] == s) mk = i;
  endfunction

  function automatic int en_ix(input int s);
    en_ix = 0;
    for (int i = 0; i < NUM_SRC; i++) if (EN_MAP[i] == s) en_ix = i;
  endfunction

  // One-cycle event; merged sources use bit 0 of their event byte
  task automatic pulse(input int s);
    @(posedge clk);
    if (mk(s) >= 0) mrg_ev[mk(s)*EV_W] <= 1'b1;
    else src_ev[s] <= 1'b1;
    @(posedge clk);
    mrg_ev <= '0;
    src_ev <= '0;
    @(posedge clk);
  endtask

  // Negative source means no call may start within the bound
  task automatic see_call(input int s);
    int n;
    n = 0;
    while (call.start !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (s < 0) chk("no call", 0, 32'(call.start));
    else begin
      chk("call start", 1, 32'(call.start));
      chk("call source", 32'(s), 32'(call.source));
      chk("call vector", 32'(3 + 8 * s), 32'(call.vector));
    end
  endtask

  task automatic ret();
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, ra[i], 32'h0000_0000);
      chk("reset value", 0, q);
    end
    wb(1'b1, OFS_CTRL, 32'h0000_0001);
    // Every source: mask for the merged ones, flag without enable, then the forced call
    for (int s = 0; s < NUM_SRC; s++) begin
      k = mk(s);
      e = en_ix(s);
      ea = OFS_EN0 + 8'(4 * (e / 6));
      if (k >= 0) begin
        pulse(s);
        wb(1'b0, OFS_FLAG, 32'h0000_0000);
        chk("masked event", 0, q);
        wb(1'b1, OFS_EVMASK + 8'(4 * k), 32'h0000_0001);
      end
      if (s == 17) begin
        pulse(s);
        wb(1'b0, OFS_FLAG, 32'h0000_0000);
        chk("watchdog other mode", 0, q);
        wdt_mode <= 1'b1;
      end
      pulse(s);
      wb(1'b0, OFS_FLAG, 32'h0000_0000);
      chk("flag", 32'h1 << s, q);
      chk("irq disabled", 0, 32'(irq));
      wb(1'b1, ea, 32'h1 << (e % 6));
      see_call(s);
      chk("irq pending", 1, 32'(irq));
      repeat (8) @(negedge clk);
      wb(1'b1, OFS_FLAG, 32'h1 << s);
      wb(1'b1, ea, 32'h0000_0000);
      ret();
      chk("irq cleared", 0, 32'(irq));
    end
    // Preemption only by a strictly higher level
    slow <= 1'b1;
    wb(1'b1, OFS_PRIO, 32'h0000_0080);
    wb(1'b1, OFS_EN0, 32'h0000_000D);
    pulse(0);
    see_call(0);
    wb(1'b1, OFS_FLAG, 32'h0000_0001);
    pulse(2);
    see_call(-1);
    pulse(3);
    see_call(3);
    wb(1'b1, OFS_FLAG, 32'h0000_0008);
    repeat (8) @(negedge clk);
    ret();
    ret();
    see_call(2);
    repeat (8) @(negedge clk);
    wb(1'b1, OFS_CTRL, 32'h0000_0000);
    chk("irq global off", 0, 32'(irq));
    wb(1'b0, OFS_FLAG, 32'h0000_0000);
    chk("flag kept", 32'h0000_0004, q);
    // Reset in mid-run must wipe flags and drop the request line
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, OFS_FLAG, 32'h0000_0000);
    chk("flag after reset", 0, q);
    chk("irq after reset", 0, 32'(irq));
    complete_run();
  end

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule // cpu_interrupt_controller_bench
